// ===== rtl/mfs_switch.sv
// multiple function light switch with APB register access
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_map.svh"
module mfs_switch #(
    parameter int W = 16,
    parameter int NUM_BLK = 64,
    parameter logic [31:0] BASE_TICK_CYC =
        32'(`MFS_BASE_TICK_NS / `MFS_CLK_PERIOD_NS)
) (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic TRG_I,
    input wire logic CANCEL_I,
    input wire logic PWR_RESTORE_I,
    input wire logic [NUM_BLK*W-1:0] BLOCK_VAL_I,
    output logic SWITCH_O,
    output logic [W-1:0] ELAPSED_O
);
    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [3:0] ctrl_q, ctrl_d;
    logic [W-1:0] off_q, off_d, hold_cfg_q, hold_cfg_d;
    logic [W-1:0] pws_q, pws_d, pwl_q, pwl_d;
    logic [31:0] src_q, src_d, prdata_q, prdata_d;
    logic wr, mapped;
    mfs_pkg::mfs_state_t state_q, state_d;
    logic [W-1:0] elapsed_q, elapsed_d, hold_q, hold_d;
    logic out_q, out_d;

    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
    assign PRDATA_O = prdata_q;

    always_comb
    begin
        mapped = 1'b1;
        prdata_d = prdata_q;
        unique case (PADDR_I)
            `MFS_OFF_CTRL: prdata_d = {28'h0, ctrl_q};
            `MFS_OFF_OFF_SPAN: prdata_d = 32'(off_q);
            `MFS_OFF_HOLD_SPAN: prdata_d = 32'(hold_cfg_q);
            `MFS_OFF_PW_START: prdata_d = 32'(pws_q);
            `MFS_OFF_PW_LEN: prdata_d = 32'(pwl_q);
            `MFS_OFF_SRC: prdata_d = src_q;
            `MFS_OFF_STATUS: prdata_d = {elapsed_q, 11'h0, state_q, out_q};
            default:
            begin
                mapped = 1'b0;
                prdata_d = 32'h0;
            end
        endcase
        if (!(PSEL_I && !PENABLE_I && !PWRITE_I))
            prdata_d = prdata_q;
        ctrl_d = ctrl_q;
        off_d = off_q;
        hold_cfg_d = hold_cfg_q;
        pws_d = pws_q;
        pwl_d = pwl_q;
        src_d = src_q;
        if (wr)
        begin
            // all spans are taken in the one selected timebase
            unique case (PADDR_I)
                `MFS_OFF_CTRL: ctrl_d = PWDATA_I[3:0];
                `MFS_OFF_OFF_SPAN: off_d = PWDATA_I[W-1:0];
                `MFS_OFF_HOLD_SPAN: hold_cfg_d = PWDATA_I[W-1:0];
                `MFS_OFF_PW_START: pws_d = PWDATA_I[W-1:0];
                `MFS_OFF_PW_LEN: pwl_d = PWDATA_I[W-1:0];
                `MFS_OFF_SRC: src_d = PWDATA_I;
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            ctrl_q <= `MFS_RST_CTRL;
            off_q <= `MFS_RST_OFF_SPAN;
            hold_cfg_q <= `MFS_RST_HOLD_SPAN;
            pws_q <= `MFS_RST_PW_START;
            pwl_q <= `MFS_RST_PW_LEN;
            src_q <= `MFS_RST_SRC;
            prdata_q <= 32'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            off_q <= off_d;
            hold_cfg_q <= hold_cfg_d;
            pws_q <= pws_d;
            pwl_q <= pwl_d;
            src_q <= src_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing value sources and timebase
    function automatic logic [W-1:0] pick(input logic [7:0] sel,
                                          input logic [W-1:0] konst,
                                          input logic [NUM_BLK*W-1:0] blk);
        logic [W-1:0] v;
        v = konst;
        if (sel[`MFS_SRC_LIVE])
            v = (int'(sel[5:0]) < NUM_BLK) ? blk[int'(sel[5:0])*W +: W]
                                           : '0;
        return v;
    endfunction

    logic [W-1:0] off_span, hold_span, pw_start, pw_len;
    logic [W:0] win_lo, win_hi;
    logic pw_en, retentive, rise, trg_q, tick;
    mfs_tick_if tif ();

    assign off_span = pick(src_q[7:0], off_q, BLOCK_VAL_I);
    assign hold_span = pick(src_q[15:8], hold_cfg_q, BLOCK_VAL_I);
    assign pw_start = pick(src_q[23:16], pws_q, BLOCK_VAL_I);
    assign pw_len = pick(src_q[31:24], pwl_q, BLOCK_VAL_I);
    assign pw_en = ctrl_q[`MFS_CTRL_PW_EN];
    assign retentive = ctrl_q[`MFS_CTRL_RET];
    assign tif.tb_sel = mfs_pkg::mfs_tb_t'(ctrl_q[`MFS_CTRL_TB_LSB +: 2]);
    assign tick = tif.tick;
    assign rise = TRG_I && !trg_q;
    // prewarning window in elapsed span, clamped at zero
    assign win_lo = (off_span > pw_start) ? {1'b0, off_span - pw_start}
                                          : '0;
    assign win_hi = win_lo + {1'b0, pw_len};

    mfs_tick #(
        .BASE_CYC(BASE_TICK_CYC)
    ) u_tick (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // switch state machine
    always_comb
    begin
        state_d = state_q;
        elapsed_d = elapsed_q;
        hold_d = hold_q;
        if (CANCEL_I || (PWR_RESTORE_I && !retentive))
        begin
            state_d = mfs_mfs_idle();
            elapsed_d = '0;
            hold_d = '0;
        end
        else
        begin
            unique case (state_q)
                mfs_pkg::MFS_IDLE:
                    if (rise)
                    begin
                        state_d = mfs_pkg::MFS_HELD;
                        hold_d = '0;
                    end
                mfs_pkg::MFS_HELD:
                    if (!TRG_I)
                    begin
                        state_d = mfs_pkg::MFS_TIMED;
                        elapsed_d = '0;
                    end
                    else if (tick)
                    begin
                        hold_d = hold_q + 1'b1;
                        if ({1'b0, hold_q} + 1'b1 >= {1'b0, hold_span})
                            state_d = mfs_pkg::MFS_PERM;
                    end
                mfs_pkg::MFS_TIMED:
                    if (rise)
                    begin
                        state_d = mfs_mfs_idle();
                        elapsed_d = '0;
                    end
                    else if (tick)
                    begin
                        elapsed_d = elapsed_q + 1'b1;
                        if ({1'b0, elapsed_q} + 1'b1 >= {1'b0, off_span})
                            state_d = mfs_mfs_idle();
                    end
                mfs_pkg::MFS_PERM:
                    if (rise)
                    begin
                        state_d = mfs_mfs_idle();
                        elapsed_d = '0;
                    end
            endcase
        end
        out_d = (state_d != mfs_pkg::MFS_IDLE) &&
                !(state_d == mfs_pkg::MFS_TIMED && pw_en &&
                  {1'b0, elapsed_d} >= win_lo &&
                  {1'b0, elapsed_d} < win_hi);
    end

    function automatic mfs_pkg::mfs_state_t mfs_mfs_idle();
        return mfs_pkg::MFS_IDLE;
    endfunction

    always_ff @(posedge REF_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_q <= mfs_pkg::MFS_IDLE;
            elapsed_q <= '0;
            hold_q <= '0;
            out_q <= 1'b0;
            trg_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            elapsed_q <= elapsed_d;
            hold_q <= hold_d;
            out_q <= out_d;
            trg_q <= TRG_I;
        end
    end

    assign SWITCH_O = out_q;
    assign ELAPSED_O = elapsed_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    logic quiet;
    assign quiet = !CANCEL_I && !(PWR_RESTORE_I && !retentive);

    sequence s_released;
        state_q == mfs_pkg::MFS_HELD && !TRG_I && quiet;
    endsequence
    sequence s_timed_start;
        state_q == mfs_pkg::MFS_TIMED && elapsed_q == '0 && out_q;
    endsequence

    property p_rise_on;
        state_q == mfs_pkg::MFS_IDLE && rise && quiet |=> out_q;
    endproperty
    a_rise_on: assert property (p_rise_on)
        else $error("rising trigger did not switch output on");

    property p_perm;
        state_q == mfs_pkg::MFS_HELD && TRG_I && tick && quiet &&
        ({1'b0, hold_q} + 1'b1 >= {1'b0, hold_span})
        |=> state_q == mfs_pkg::MFS_PERM && out_q;
    endproperty
    a_perm: assert property (p_perm)
        else $error("hold span did not latch permanent light");

    property p_release;
        s_released |=> s_timed_start;
    endproperty
    a_release: assert property (p_release)
        else $error("early release did not start off-delay");

    property p_expire;
        state_q == mfs_pkg::MFS_TIMED && tick && !rise && quiet &&
        ({1'b0, elapsed_q} + 1'b1 >= {1'b0, off_span})
        |=> state_q == mfs_pkg::MFS_IDLE && !out_q;
    endproperty
    a_expire: assert property (p_expire)
        else $error("output not off at off-delay expiry");

    property p_prewarn;
        state_q == mfs_pkg::MFS_TIMED && !tick && !rise && quiet && pw_en &&
        {1'b0, elapsed_q} >= win_lo && {1'b0, elapsed_q} < win_hi
        |=> !out_q;
    endproperty
    a_prewarn: assert property (p_prewarn)
        else $error("output not dropped during prewarning");

    property p_pulse_off;
        (state_q == mfs_pkg::MFS_TIMED || state_q == mfs_pkg::MFS_PERM) &&
        rise && quiet |=> !out_q && elapsed_q == '0;
    endproperty
    a_pulse_off: assert property (p_pulse_off)
        else $error("trigger pulse did not switch output off");

    property p_cancel;
        CANCEL_I |=> !out_q && elapsed_q == '0 &&
        state_q == mfs_pkg::MFS_IDLE;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("cancel did not clear output and elapsed span");

    property p_nonret;
        PWR_RESTORE_I && !retentive |=> !out_q && elapsed_q == '0;
    endproperty
    a_nonret: assert property (p_nonret)
        else $error("non-retentive restore kept old state");

    property p_count;
        state_q == mfs_pkg::MFS_TIMED && !rise && quiet &&
        ({1'b0, elapsed_q} + 1'b1 < {1'b0, off_span})
        |=> elapsed_q == $past(elapsed_q) + W'($past(tick));
    endproperty
    a_count: assert property (p_count)
        else $error("elapsed span did not follow the tick");
endmodule
`default_nettype wire

// ===== rtl/mfs_map.svh
// register offsets, field positions, reset values and timing constants
`ifndef MFS_MAP_SVH
`define MFS_MAP_SVH

`define MFS_OFF_CTRL 8'h00
`define MFS_OFF_OFF_SPAN 8'h04
`define MFS_OFF_HOLD_SPAN 8'h08
`define MFS_OFF_PW_START 8'h0C
`define MFS_OFF_PW_LEN 8'h10
`define MFS_OFF_SRC 8'h14
`define MFS_OFF_STATUS 8'h18

`define MFS_CTRL_PW_EN 0
`define MFS_CTRL_RET 1
`define MFS_CTRL_TB_LSB 2
`define MFS_SRC_LIVE 7
`define MFS_STAT_ELAPSED_LSB 16

`define MFS_RST_CTRL 4'h0
`define MFS_RST_OFF_SPAN 16'h0003
`define MFS_RST_HOLD_SPAN 16'h0002
`define MFS_RST_PW_START 16'h0000
`define MFS_RST_PW_LEN 16'h0000
`define MFS_RST_SRC 32'h0000_0000

`define MFS_CLK_PERIOD_NS 25
`define MFS_BASE_TICK_NS 10000000
`define MFS_SEC_DIV 7'h64
`define MFS_MIN_DIV 6'h3C

`endif

// ===== rtl/mfs_pkg.sv
// types shared by the switch and its timebase
package mfs_pkg;
    typedef enum logic [3:0] {
        MFS_IDLE  = 4'b0001,
        MFS_HELD  = 4'b0010,
        MFS_TIMED = 4'b0100,
        MFS_PERM  = 4'b1000
    } mfs_state_t;

    typedef enum logic [1:0] {
        MFS_TB_BASE = 2'h0,
        MFS_TB_SEC  = 2'h1,
        MFS_TB_MIN  = 2'h2,
        MFS_TB_RSVD = 2'h3
    } mfs_tb_t;
endpackage

// ===== rtl/mfs_tick_if.sv
// timebase selection and tick between switch and timebase
`timescale 1ns/1ps
`default_nettype none
interface mfs_tick_if;
    mfs_pkg::mfs_tb_t tb_sel;
    logic tick;
    modport src (input tb_sel, output tick);
    modport snk (output tb_sel, input tick);
endinterface
`default_nettype wire

// ===== rtl/mfs_tick.sv
// timebase tick generator: base period, seconds, minutes
`timescale 1ns/1ps
`default_nettype none
`include "mfs_map.svh"
module mfs_tick #(
    parameter logic [31:0] BASE_CYC = 32'd400000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mfs_tick_if.src tif
);
    logic [31:0] base_q, base_d;
    logic [6:0] sec_q, sec_d;
    logic [5:0] min_q, min_d;
    logic base_tick, sec_tick, min_tick;

    assign base_tick = (base_q == BASE_CYC - 32'd1);
    assign sec_tick = base_tick && (sec_q == `MFS_SEC_DIV - 7'h1);
    assign min_tick = sec_tick && (min_q == `MFS_MIN_DIV - 6'h1);

    always_comb
    begin
        base_d = base_tick ? 32'h0 : base_q + 32'h1;
        sec_d = sec_q;
        min_d = min_q;
        if (base_tick)
            sec_d = sec_tick ? 7'h0 : sec_q + 7'h1;
        if (sec_tick)
            min_d = min_tick ? 6'h0 : min_q + 6'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            base_q <= 32'h0;
            sec_q <= 7'h0;
            min_q <= 6'h0;
        end
        else
        begin
            base_q <= base_d;
            sec_q <= sec_d;
            min_q <= min_d;
        end
    end

    always_comb
    begin
        unique case (tif.tb_sel)
            mfs_pkg::MFS_TB_SEC: tif.tick = sec_tick;
            mfs_pkg::MFS_TB_MIN: tif.tick = min_tick;
            default: tif.tick = base_tick;
        endcase
    end
endmodule
`default_nettype wire

// ===== verif/mfs_button_model.sv
// pushbutton, cancel and power-restore stimulus for the switch
`timescale 1ns/1ps
`default_nettype none
module mfs_button_model (
    input wire logic clk_i,
    output logic trg_o,
    output logic cancel_o,
    output logic restore_o
);
    initial
    begin
        trg_o = 1'b0;
        cancel_o = 1'b0;
        restore_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // press for n cycles, cancel optionally raised alongside the press
    task automatic press(input int n, input logic c);
        @(posedge clk_i);
        trg_o <= 1'b1;
        cancel_o <= c;
        repeat (n) @(posedge clk_i);
        trg_o <= 1'b0;
        cancel_o <= 1'b0;
    endtask

    // one-cycle cancel or power-restore strobe
    task automatic strobe(input logic c, input logic r);
        @(posedge clk_i);
        cancel_o <= c;
        restore_o <= r;
        @(posedge clk_i);
        cancel_o <= 1'b0;
        restore_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verif/multi_function_light_switch_tb.sv
// self-checking bench of the multiple function light switch
`timescale 1ns/1ps
`default_nettype none
`include "mfs_map.svh"
module multi_function_light_switch_tb;
    localparam int TC = 4;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic x;
    } mfs_row_t;
    localparam mfs_row_t ROWS [14] = '{
        '{1'b0, `MFS_OFF_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_OFF_SPAN, 32'h0, 32'h3, 1'b0},
        '{1'b0, `MFS_OFF_HOLD_SPAN, 32'h0, 32'h2, 1'b0},
        '{1'b0, `MFS_OFF_PW_START, 32'h0, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_PW_LEN, 32'h0, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_SRC, 32'h0, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_STATUS, 32'h0, 32'h2, 1'b0},
        '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1},
        '{1'b1, `MFS_OFF_STATUS, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_STATUS, 32'h0, 32'h2, 1'b0},
        '{1'b1, `MFS_OFF_SRC, 32'h45, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_SRC, 32'h0, 32'h45, 1'b0},
        '{1'b1, `MFS_OFF_OFF_SPAN, 32'h10005, 32'h0, 1'b0},
        '{1'b0, `MFS_OFF_OFF_SPAN, 32'h0, 32'h5, 1'b0}
    };
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [63:0] blk = 64'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic trg;
    logic cxl;
    logic rsto;
    logic sw;
    logic [15:0] ela;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    always #12.5 clk = ~clk;

    mfs_switch #(.W(16), .NUM_BLK(4), .BASE_TICK_CYC(32'd4)) DUT (
        .REF_CLK_I(clk),
        .SYS_RST_I(rst),
        .PSEL_I(psel),
        .PENABLE_I(pen),
        .PWRITE_I(pwr),
        .PADDR_I(padr),
        .PWDATA_I(pwd),
        .PRDATA_O(prd),
        .PREADY_O(prdy),
        .PSLVERR_O(perr),
        .TRG_I(trg),
        .CANCEL_I(cxl),
        .PWR_RESTORE_I(rsto),
        .BLOCK_VAL_I(blk),
        .SWITCH_O(sw),
        .ELAPSED_O(ela)
    );

    mfs_button_model btn (
        .clk_i(clk),
        .trg_o(trg),
        .cancel_o(cxl),
        .restore_o(rsto)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h, want %h", $time, s, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wait_sw(input logic v, input int m);
        n = 0;
        while (sw !== v && n < m)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 26000)
        begin
            miscompares++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(sw, 1'b0);
        chk(ela, 16'h0);
        for (int i = 0; i < 14; i++)
        begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w)
            begin
                chk(rd, ROWS[i].e);
                chk(err, ROWS[i].x);
            end
        end
        $display("register table done");
        btn.press(1, 1'b0);
        wait_sw(1'b1, 3);
        chk(sw, 1'b1);
        wait_sw(1'b0, 100);
        chk(n >= 4 * TC && n <= 5 * TC + 3, 1'b1);
        rd = ela;
        repeat (10) @(negedge clk);
        chk(ela, rd);
        btn.press(16, 1'b0);
        repeat (40) @(negedge clk);
        chk(sw, 1'b1);
        apb(1'b0, `MFS_OFF_STATUS, 32'h0);
        chk(rd[4:1], 4'h8);
        btn.press(1, 1'b0);
        wait_sw(1'b0, 4);
        chk(sw, 1'b0);
        chk(ela, 16'h0);
        btn.press(1, 1'b0);
        repeat (8) @(negedge clk);
        btn.press(1, 1'b0);
        wait_sw(1'b0, 4);
        chk(sw, 1'b0);
        $display("pulse, hold and retrigger done");
        btn.press(1, 1'b0);
        repeat (6) @(negedge clk);
        btn.strobe(1'b1, 1'b0);
        wait_sw(1'b0, 4);
        chk(sw, 1'b0);
        chk(ela, 16'h0);
        btn.press(1, 1'b1);
        repeat (4) @(negedge clk);
        chk(sw, 1'b0);
        $display("cancel done");
        apb(1'b1, `MFS_OFF_CTRL, 32'h1);
        apb(1'b1, `MFS_OFF_OFF_SPAN, 32'hA);
        apb(1'b1, `MFS_OFF_PW_START, 32'h4);
        apb(1'b1, `MFS_OFF_PW_LEN, 32'h2);
        btn.press(1, 1'b0);
        n = 0;
        for (int i = 0; i < 80; i++)
        begin
            rd[0] = sw;
            @(negedge clk);
            if (rd[0] === 1'b1 && sw === 1'b0)
                n++;
        end
        chk(n, 2);
        $display("prewarning done");
        apb(1'b1, `MFS_OFF_CTRL, 32'h2);
        btn.press(1, 1'b0);
        btn.strobe(1'b0, 1'b1);
        @(negedge clk);
        chk(sw, 1'b1);
        wait_sw(1'b0, 100);
        apb(1'b1, `MFS_OFF_CTRL, 32'h0);
        btn.press(1, 1'b0);
        btn.strobe(1'b0, 1'b1);
        repeat (2) @(negedge clk);
        chk(sw, 1'b0);
        chk(ela, 16'h0);
        $display("power restore done");
        @(posedge clk);
        blk <= 64'h0000_0000_0001_0000;
        apb(1'b1, `MFS_OFF_SRC, 32'h81);
        btn.press(1, 1'b0);
        wait_sw(1'b1, 3);
        wait_sw(1'b0, 30);
        chk(n <= 2 * TC + 3, 1'b1);
        apb(1'b1, `MFS_OFF_SRC, 32'h0);
        apb(1'b1, `MFS_OFF_CTRL, 32'h4);
        btn.press(1, 1'b0);
        repeat (60) @(negedge clk);
        chk(ela, 16'h0);
        chk(sw, 1'b1);
        btn.strobe(1'b1, 1'b0);
        // minute timebase: first minute tick lands a fixed time after reset
        apb(1'b1, `MFS_OFF_CTRL, 32'h8);
        btn.press(1, 1'b0);
        while (ela === 16'h0 && cyc < 24100)
            @(negedge clk);
        chk(cyc, 16 + 4 * `MFS_SEC_DIV * `MFS_MIN_DIV);
        chk(sw, 1'b1);
        $display("live value and timebase done");
        // reset in mid-run while the off-delay runs
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(sw, 1'b0);
        chk(ela, 16'h0);
        apb(1'b0, `MFS_OFF_CTRL, 32'h0);
        chk(rd, `MFS_RST_CTRL);
        $display("mid-run reset done");
        end_sim();
    end
endmodule
`default_nettype wire
